// ===== pkg/dmc_map.vh
`ifndef DMC_MAP_VH
`define DMC_MAP_VH
// register select on bank-address pins
`define DMC_SEL_MAIN 3'h0
`define DMC_SEL_EXT1 3'h1
`define DMC_SEL_EXT2 3'h2
`define DMC_SEL_EXT3 3'h3
// main mode register fields
`define DMC_MR_DLL_RESET 8
`define DMC_MR_WR_LSB 9
`define DMC_MR_PD_EXIT 12
// extended register one fields
`define DMC_EMR_DLL_DIS 0
`define DMC_EMR_DRIVE 1
`define DMC_EMR_RTT_LO 2
`define DMC_EMR_RTT_HI 6
`define DMC_EMR_OCD_LSB 7
`define DMC_EMR_OUT_DIS 12
// extended register two field
`define DMC_EXTENDED_MODE_REGISTER_TWO_SRF 7
// write recovery limits, clocks
`define DMC_WR_MIN 2
`define DMC_WR_MAX 8
// timing in clocks
`define DMC_DLL_LOCK_CLKS 200
`define DMC_ODT_WAIT_CLKS 8
// command pin patterns {ras_n, cas_n, we_n}
`define DMC_CMD_NOP 3'h7
`define DMC_CMD_LOAD 3'h0
`define DMC_CMD_PRE 3'h2
`define DMC_CMD_REF 3'h1
`endif

// ===== rtl/dmc_mode_ctrl.v
// Contract
// RULE1: device orders burst beats; controller only programs burst type.
// RULE2: device delays auto precharge by write-recovery clocks after last beat.
// RULE3: write-recovery field is programmed only with two to eight clocks; the init DLL reset load (13'h0100) writes field code zero, one clock.
// RULE4: write-recovery clocks equal time over period, rounded up.
// RULE5: exit select zero gives fast-exit active power-down.
// RULE6: exit select one gives slow-exit active power-down.
// RULE7: exit select bit does not affect precharge power-down.
// RULE8: DLL enabled at initialization, each enable followed by DLL reset load.
// RULE9: device disables and re-enables DLL around self refresh.
// RULE10: wait 200 clocks after DLL enable and reset before a read.
// RULE11: DLL off below 25 MHz: follow auto refresh with precharge-all.
// RULE12: drive strength bit zero full, one reduced.
// RULE13: output disable bit one turns off data and strobe outputs.
// RULE14: self-refresh rate bit set above 85 C; other bits zero.
// RULE15: termination select uses only 50, 75 or 150 ohm codes.
// RULE16: termination input honoured only in active and power-down states.
// RULE17: termination input low before self refresh and during initialization.
// RULE18: wait eight clocks after termination-enabling load before termination high.
// RULE19: load only when banks idle, then wait mode-load delay.
// RULE20: bits above twelve and third bank bit written as zero.
// RULE21: registers hold values until reloaded.
// RULE22: calibration bits set to one, then cleared during initialization.
// RULE23: bank bits select main, extended one, two or three register.
// RULE24: DLL reset bit clears itself in the device.
// RULE25: device captures address and bank bits on load edge.
`timescale 1ns/10ps
`include "dmc_map.vh"
module dmc_mode_ctrl #(
    parameter MODE_LOAD_CLKS = 2,
    parameter TWR_PS = 15000,
    parameter TCK_PS = 8000,
    parameter TWO_FAST_REF = 0
) (
    // clock, reset, enable
    input wire clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    // user order
    input wire start_init_i,
    input wire load_req_i,
    input wire [1:0] load_sel_i,
    input wire [12:0] load_val_i,
    input wire banks_idle_i,
    input wire hot_case_i,
    input wire slow_clk_dll_off_i,
    input wire odt_req_i,
    input wire self_refresh_req_i,
    input wire read_req_i,
    // user status
    output wire load_ready_o,
    output reg load_done_o,
    output reg init_done_o,
    output reg read_allowed_o,
    output reg load_error_o,
    output reg [3:0] wr_clocks_o,
    // device pins
    output reg ras_n_o,
    output reg cas_n_o,
    output reg we_n_o,
    output reg [12:0] addr_o,
    output reg [2:0] ba_o,
    output reg odt_o
);
    // wr field code for a clock count
    function [2:0] wr_code;
        input [3:0] clks;
        begin
            wr_code = clks[2:0] - 3'h1;
        end
    endfunction
    // rounded-up write recovery clocks
    localparam integer WR_RAW = (TWR_PS + TCK_PS - 1) / TCK_PS; // RULE4
    localparam integer WR_CLK = (WR_RAW < `DMC_WR_MIN) ? `DMC_WR_MIN :
        ((WR_RAW > `DMC_WR_MAX) ? `DMC_WR_MAX : WR_RAW); // RULE3
    localparam [3:0] WR_CLK4 = WR_CLK[3:0];
    // states
    localparam S_IDLE = 4'h0;
    localparam S_PRE1 = 4'h1;
    localparam S_EXTENDED_MODE_REGISTER_TWO = 4'h2;
    localparam S_EXTENDED_MODE_REGISTER_THREE = 4'h3;
    localparam S_DLLEN = 4'h4;
    localparam S_DLLRST = 4'h5;
    localparam S_PRE2 = 4'h6;
    localparam S_REF1 = 4'h7;
    localparam S_REF2 = 4'h8;
    localparam S_MRSET = 4'h9;
    localparam S_OCDDEF = 4'ha;
    localparam S_OCDEXIT = 4'hb;
    localparam S_RUN = 4'hc;
    localparam S_WAIT = 4'hd;
    localparam S_PREALL = 4'he;
    reg [3:0] state;
    reg [3:0] ret_state;
    // return point after a chasing precharge-all
    reg [3:0] pre_ret;
    reg [7:0] wait_cnt;
    reg [7:0] lock_cnt;
    reg [3:0] odt_cnt;
    reg init_done;
    reg [12:0] emr1_shadow;
    // legal user load check
    wire rtt_on = load_val_i[`DMC_EMR_RTT_LO] | load_val_i[`DMC_EMR_RTT_HI];
    wire wr_bad = (load_sel_i == 2'h0) && (load_val_i[11:9] == 3'h0); // RULE3
    assign load_ready_o = (state == S_RUN) && banks_idle_i; // RULE19
    // issue a command with given address
    task issue;
        input [2:0] cmd;
        input [2:0] bank;
        input [12:0] val;
        begin
            {ras_n_o, cas_n_o, we_n_o} <= cmd;
            ba_o <= bank; // RULE20 RULE23
            addr_o <= val;
        end
    endtask
    // main sequencer
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state <= S_IDLE;
            ret_state <= S_IDLE;
            pre_ret <= S_IDLE;
            wait_cnt <= 8'h00;
            {ras_n_o, cas_n_o, we_n_o} <= `DMC_CMD_NOP;
            addr_o <= 13'h0000;
            ba_o <= 3'h0;
            load_done_o <= 1'b0;
            load_error_o <= 1'b0;
            init_done <= 1'b0;
            emr1_shadow <= 13'h0000;
        end
        else if (ce_i)
        begin
            {ras_n_o, cas_n_o, we_n_o} <= `DMC_CMD_NOP;
            load_done_o <= 1'b0;
            load_error_o <= 1'b0;
            case (state)
                // init opens with precharge all, then extended two and three
                S_IDLE:
                    if (start_init_i)
                    begin
                        issue(`DMC_CMD_PRE, 3'h0, 13'h0400);
                        ret_state <= S_EXTENDED_MODE_REGISTER_TWO;
                        state <= S_WAIT;
                    end
                S_EXTENDED_MODE_REGISTER_TWO:
                begin
                    issue(`DMC_CMD_LOAD, `DMC_SEL_EXT2,
                        {5'h00, hot_case_i, 7'h00}); // RULE14
                    ret_state <= S_EXTENDED_MODE_REGISTER_THREE;
                    state <= S_WAIT;
                end
                S_EXTENDED_MODE_REGISTER_THREE:
                begin
                    issue(`DMC_CMD_LOAD, `DMC_SEL_EXT3, 13'h0000);
                    ret_state <= S_DLLEN;
                    state <= S_WAIT;
                end
                // DLL enable, always chased by a DLL reset load
                S_DLLEN:
                begin
                    issue(`DMC_CMD_LOAD, `DMC_SEL_EXT1, 13'h0000); // RULE8
                    ret_state <= S_DLLRST;
                    state <= S_WAIT;
                end
                S_DLLRST:
                begin
                    issue(`DMC_CMD_LOAD, `DMC_SEL_MAIN, 13'h0100); // RULE8
                    ret_state <= S_PRE2;
                    state <= S_WAIT;
                end
                S_PRE2:
                begin
                    issue(`DMC_CMD_PRE, 3'h0, 13'h0400);
                    ret_state <= S_REF1;
                    state <= S_WAIT;
                end
                // refreshes, each chased by precharge-all on a slow clock with DLL off
                S_REF1:
                begin
                    issue(`DMC_CMD_REF, 3'h0, 13'h0000);
                    pre_ret <= S_REF2;
                    ret_state <= slow_clk_dll_off_i ? S_PREALL : S_REF2; // RULE11
                    state <= S_WAIT;
                end
                S_REF2:
                begin
                    issue(`DMC_CMD_REF, 3'h0, 13'h0000);
                    pre_ret <= S_MRSET;
                    ret_state <= slow_clk_dll_off_i ? S_PREALL : S_MRSET; // RULE11
                    state <= S_WAIT;
                end
                S_MRSET:
                begin
                    // sequential burst of four, write recovery, fast exit
                    issue(`DMC_CMD_LOAD, `DMC_SEL_MAIN,
                        {1'b0, wr_code(WR_CLK4), 9'h032}); // RULE1 RULE3 RULE5
                    ret_state <= S_OCDDEF;
                    state <= S_WAIT;
                end
                // calibration default, then calibration exit
                S_OCDDEF:
                begin
                    issue(`DMC_CMD_LOAD, `DMC_SEL_EXT1, 13'h0380); // RULE22
                    ret_state <= S_OCDEXIT;
                    state <= S_WAIT;
                end
                S_OCDEXIT:
                begin
                    issue(`DMC_CMD_LOAD, `DMC_SEL_EXT1, 13'h0000); // RULE22
                    ret_state <= S_RUN;
                    state <= S_WAIT;
                end
                // user loads, refused on a reserved write-recovery code
                S_RUN:
                begin
                    init_done <= 1'b1;
                    if (load_req_i && banks_idle_i) // RULE19
                    begin
                        if (wr_bad)
                            load_error_o <= 1'b1;
                        else
                        begin
                            issue(`DMC_CMD_LOAD, {1'b0, load_sel_i}, load_val_i);
                            if (load_sel_i == 2'h1)
                                emr1_shadow <= load_val_i;
                            ret_state <= S_RUN;
                            state <= S_WAIT;
                            load_done_o <= 1'b1;
                        end
                    end
                end
                // precharge-all after a refresh, then resume the sequence
                S_PREALL:
                begin
                    issue(`DMC_CMD_PRE, 3'h0, 13'h0400); // RULE11
                    ret_state <= pre_ret;
                    state <= S_WAIT;
                end
                // NOP for the mode-load delay, then go on
                S_WAIT:
                    if (wait_cnt >= MODE_LOAD_CLKS[7:0] - 8'h01)
                    begin
                        wait_cnt <= 8'h00;
                        state <= ret_state; // RULE19
                    end
                    else
                        wait_cnt <= wait_cnt + 8'h01;
                // unused codes fall back to idle
                default:
                    state <= S_IDLE;
            endcase
        end
    end
    // DLL lock counter restarted by DLL reset load
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            lock_cnt <= 8'h00;
            read_allowed_o <= 1'b0;
            init_done_o <= 1'b0;
            wr_clocks_o <= 4'h0;
        end
        else if (ce_i)
        begin
            wr_clocks_o <= WR_CLK4;
            init_done_o <= init_done; // stays high until reset
            // any DLL reset load restarts the lock count
            if (state == S_DLLRST || (state == S_RUN && load_req_i && banks_idle_i
                && load_sel_i == 2'h0 && load_val_i[`DMC_MR_DLL_RESET]))
            begin
                lock_cnt <= 8'h00;
                read_allowed_o <= 1'b0;
            end
            else if (lock_cnt >= `DMC_DLL_LOCK_CLKS - 1)
                read_allowed_o <= 1'b1; // RULE10
            else
                lock_cnt <= lock_cnt + 8'h01;
        end
    end
    // termination pin: held low until enabled load plus eight clocks
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            odt_cnt <= 4'h0;
            odt_o <= 1'b0;
        end
        else if (ce_i)
        begin
            // a load that turns termination on restarts the wait
            if (state == S_RUN && load_req_i && banks_idle_i &&
                load_sel_i == 2'h1 && rtt_on)
                odt_cnt <= 4'h0; // RULE18
            else if (odt_cnt < `DMC_ODT_WAIT_CLKS)
                odt_cnt <= odt_cnt + 4'h1;
            odt_o <= init_done && !self_refresh_req_i && odt_req_i &&
                (odt_cnt >= `DMC_ODT_WAIT_CLKS) &&
                (emr1_shadow[`DMC_EMR_RTT_LO] | emr1_shadow[`DMC_EMR_RTT_HI]); // RULE16 RULE17
        end
    end
endmodule // dmc_mode_ctrl

// ===== verif/dmc_dev_model.sv
`timescale 1ns/10ps
`include "dmc_map.vh"
module dmc_dev_model (
    // device pins
    input wire clk_i,
    input wire [2:0] cmd_i,
    input wire [12:0] addr_i,
    input wire [2:0] ba_i
);
reg [12:0] regs [0:3];
// capture a load whole, dll reset bit self-clears
always @(posedge clk_i)
begin
    if (cmd_i == `DMC_CMD_LOAD)
        regs[ba_i[1:0]] <= (ba_i[1:0] == 2'h0) ? (addr_i & 13'h1eff) : addr_i;
end
// settings seen by the output stage
wire slow_exit = regs[0][12];
wire reduced_drive = regs[1][1];
wire outputs_off = regs[1][12];
wire [1:0] term_sel = {regs[1][6], regs[1][2]};
wire interleaved = regs[0][3];
wire [3:0] wr_clocks = {1'b0, regs[0][11:9]} + 4'h1;
wire dll_on = !regs[1][0];
endmodule // dmc_dev_model

// ===== verif/dmc_mode_ctrl_properties.sv
`timescale 1ns/10ps
`include "dmc_map.vh"
module dmc_mode_ctrl_properties #(
    parameter MODE_LOAD_CLKS = 2
) (
    // clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // user side
    input wire [1:0] load_sel_i,
    input wire [12:0] load_val_i,
    input wire hot_case_i, self_refresh_req_i, load_done_o, init_done_o, read_allowed_o,
    // device pins
    input wire ras_n_o, cas_n_o, we_n_o, odt_o,
    input wire [12:0] addr_o,
    input wire [2:0] ba_o
);
wire ld = {ras_n_o, cas_n_o, we_n_o} == `DMC_CMD_LOAD;
wire nop = {ras_n_o, cas_n_o, we_n_o} == `DMC_CMD_NOP;
wire ld1 = ld && ba_o[1:0] == 2'h1;
wire dll_rst = ld && ba_o[1:0] == 2'h0 && addr_o[8];
reg [7:0] gap, tcnt, dcnt;
reg rtt_on, ocd_set;
reg [2:0] ocd_last;
// cycles since last command, ext1 load and dll reset
always @(posedge clk_i)
begin
    if (sys_rst_i)
    begin
        {gap, tcnt, dcnt} <= {8'hff, 8'h0, 8'h0};
        {rtt_on, ocd_set, ocd_last} <= 5'h0;
    end
    else
    begin
        gap <= nop ? gap + {7'h0, gap != 8'hff} : 8'h1;
        tcnt <= ld1 ? 8'h1 : tcnt + {7'h0, tcnt != 8'hff};
        dcnt <= dll_rst ? 8'h1 : dcnt + {7'h0, dcnt != 8'h0 && dcnt != 8'hff};
        rtt_on <= ld1 ? (addr_o[2] | addr_o[6]) : rtt_on;
        ocd_set <= ocd_set | (ld1 && addr_o[9:7] == 3'h7);
        ocd_last <= ld1 ? addr_o[9:7] : ocd_last;
    end
end
default clocking @(posedge clk_i); endclocking
default disable iff (sys_rst_i);
property p_gap; !nop |-> gap > MODE_LOAD_CLKS; endproperty
a_gap: assert property (p_gap) else $error("command too soon");
property p_echo; load_done_o |-> ld && ba_o == {1'b0, $past(load_sel_i)} && addr_o == $past(load_val_i); endproperty
a_echo: assert property (p_echo) else $error("load pins wrong");
property p_wr; ld && ba_o[1:0] == 2'h0 && !addr_o[8] |-> addr_o[11:9] != 3'h0; endproperty
a_wr: assert property (p_wr) else $error("reserved wr code");
property p_odt; odt_o |-> rtt_on && tcnt >= 8'h8; endproperty
a_odt: assert property (p_odt) else $error("odt early");
property p_sr; self_refresh_req_i |=> !odt_o; endproperty
a_sr: assert property (p_sr) else $error("odt in self refresh");
property p_lock; read_allowed_o |-> dcnt >= 8'd200; endproperty
a_lock: assert property (p_lock) else $error("read before lock");
property p_ocd; $rose(init_done_o) |-> ocd_set && ocd_last == 3'h0; endproperty
a_ocd: assert property (p_ocd) else $error("calibration bits");
property p_srf; ld && ba_o[1:0] == 2'h2 && !init_done_o |-> addr_o == {5'h0, hot_case_i, 7'h0}; endproperty
a_srf: assert property (p_srf) else $error("refresh rate bit");
endmodule // dmc_mode_ctrl_properties
bind dmc_mode_ctrl dmc_mode_ctrl_properties #(.MODE_LOAD_CLKS(MODE_LOAD_CLKS)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_sel_i(load_sel_i), .load_val_i(load_val_i),
    .hot_case_i(hot_case_i), .self_refresh_req_i(self_refresh_req_i),
    .load_done_o(load_done_o), .init_done_o(init_done_o), .read_allowed_o(read_allowed_o),
    .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .odt_o(odt_o),
    .addr_o(addr_o), .ba_o(ba_o));

// ===== verif/tb_dmc_mode_ctrl.sv
`timescale 1ns/10ps
module tb_dmc_mode_ctrl;
localparam TWR = 20000;
localparam TCK = 8000;
localparam [12:0] WR = (TWR + TCK - 1) / TCK;
reg clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, start_init_i = 1'b0, load_req_i = 1'b0;
reg banks_idle_i = 1'b1, hot_case_i = 1'b0, slow_clk_dll_off_i = 1'b0, odt_req_i = 1'b0;
reg self_refresh_req_i = 1'b0, read_req_i = 1'b0;
reg [1:0] load_sel_i = 2'h0;
reg [12:0] load_val_i = 13'h0;
wire load_ready_o, load_done_o, init_done_o, read_allowed_o, load_error_o;
wire ras_n_o, cas_n_o, we_n_o, odt_o;
wire [3:0] wr_clocks_o;
wire [12:0] addr_o;
wire [2:0] ba_o;
integer fail_count = 0, checked = 0, i, n, k, pre_seen;
reg [31:0] r;
reg [12:0] mdl [0:3];
reg [12:0] v;
reg [1:0] s;
dmc_mode_ctrl #(.TWR_PS(TWR), .TCK_PS(TCK)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .start_init_i(start_init_i),
    .load_req_i(load_req_i), .load_sel_i(load_sel_i), .load_val_i(load_val_i),
    .banks_idle_i(banks_idle_i), .hot_case_i(hot_case_i),
    .slow_clk_dll_off_i(slow_clk_dll_off_i), .odt_req_i(odt_req_i),
    .self_refresh_req_i(self_refresh_req_i), .read_req_i(read_req_i),
    .load_ready_o(load_ready_o), .load_done_o(load_done_o), .init_done_o(init_done_o),
    .read_allowed_o(read_allowed_o), .load_error_o(load_error_o), .wr_clocks_o(wr_clocks_o),
    .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .addr_o(addr_o), .ba_o(ba_o),
    .odt_o(odt_o));
dmc_dev_model dev (.clk_i(clk_i), .cmd_i({ras_n_o, cas_n_o, we_n_o}), .addr_i(addr_o), .ba_i(ba_o));
// clock
initial
begin
    forever #4 clk_i = ~clk_i;
end
// precharge-all commands seen since reset
always @(posedge clk_i)
begin
    if (sys_rst_i)
        pre_seen <= 0;
    else if ({ras_n_o, cas_n_o, we_n_o} == 3'h2 && addr_o[10])
        pre_seen <= pre_seen + 1;
end
task cyc(input integer c);
begin
    repeat (c) @(negedge clk_i);
end
endtask
task chk(input [12:0] got, input [12:0] exp);
begin
    checked = checked + 1;
    if (got !== exp)
    begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
end
endtask
// one load, then all device registers against the model
task ld(input [1:0] sel, input [12:0] val, input bi, input [1:0] e);
begin
    n = 0;
    while (load_ready_o !== 1'b1 && n < 50)
    begin
        cyc(1);
        n = n + 1;
    end
    chk({12'h0, load_ready_o}, 13'h1);
    {load_sel_i, load_val_i, banks_idle_i, load_req_i} = {sel, val, bi, 1'b1};
    cyc(1);
    chk({11'h0, load_done_o, load_error_o}, {11'h0, e});
    {banks_idle_i, load_req_i} = 2'b10;
    cyc(1);
    if (e == 2'b10)
        mdl[sel] = (sel == 2'h0) ? (val & 13'h1eff) : val;
    cyc(1);
    for (i = 0; i < 4; i = i + 1)
        chk(dev.regs[i], mdl[i]);
end
endtask
// hold reset 16 clocks, start init, wait for it to finish
task run_init;
begin
    cyc(16);
    sys_rst_i = 1'b0;
    cyc(1);
    start_init_i = 1'b1;
    cyc(1);
    start_init_i = 1'b0;
    n = 0;
    while (init_done_o !== 1'b1 && n < 2000)
    begin
        cyc(1);
        n = n + 1;
    end
    chk({12'h0, init_done_o}, 13'h1);
end
endtask
task give_verdict;
begin
    if (fail_count == 0 && checked > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
end
endtask
// watchdog
initial
begin
    #(8 * 20000);
    fail_count = fail_count + 1;
    give_verdict;
end
// main sequence
initial
begin
    r = $urandom(32'h69bd05d2);
    hot_case_i = r[0];
    run_init;
    chk(pre_seen[12:0], 13'h2);
    mdl[0] = 13'h032 | ((WR - 13'h1) << 9);
    mdl[1] = 13'h0;
    mdl[2] = hot_case_i ? 13'h080 : 13'h0;
    mdl[3] = 13'h0;
    for (i = 0; i < 4; i = i + 1)
        chk(dev.regs[i], mdl[i]);
    chk({9'h0, wr_clocks_o}, WR);
    chk({9'h0, dev.wr_clocks}, WR);
    chk({8'h0, dev.interleaved, dev.slow_exit, dev.reduced_drive, dev.outputs_off,
        dev.dll_on}, 13'h1);
    cyc(210);
    chk({12'h0, read_allowed_o}, 13'h1);
    // every nonzero termination code, odt held back then on
    odt_req_i = 1'b1;
    for (k = 1; k < 4; k = k + 1)
    begin
        v = 13'h0;
        v[6] = k[1];
        v[2] = k[0];
        ld(2'h1, v, 1'b1, 2'b10);
        chk({11'h0, dev.term_sel}, k[12:0]);
        cyc(4);
        chk({12'h0, odt_o}, 13'h0);
        cyc(8);
        chk({12'h0, odt_o}, 13'h1);
    end
    self_refresh_req_i = 1'b1;
    cyc(2);
    chk({12'h0, odt_o}, 13'h0);
    {self_refresh_req_i, odt_req_i} = 2'b00;
    ld(2'h0, 13'h032, 1'b1, 2'b01);
    ld(2'h2, 13'h080, 1'b0, 2'b00);
    ld(2'h0, 13'h332, 1'b1, 2'b10);
    chk({12'h0, read_allowed_o}, 13'h0);
    cyc(205);
    chk({12'h0, read_allowed_o}, 13'h1);
    // frozen by the clock enable: a request must not be taken
    ce_i = 1'b0;
    ld(2'h3, 13'h1fff, 1'b1, 2'b00);
    ce_i = 1'b1;
    for (k = 0; k < 16; k = k + 1)
    begin
        r = $urandom;
        {s, v} = r[14:0];
        if (s == 2'h0)
            v = (v & 13'h1eff) | 13'h200;
        if (s == 2'h1)
            v[0] = 1'b0;
        ld(s, v, 1'b1, 2'b10);
    end
    // reset in mid-run, init again with the slow-clock DLL-off flag
    sys_rst_i = 1'b1;
    slow_clk_dll_off_i = 1'b1;
    run_init;
    chk(pre_seen[12:0], 13'h4);
    give_verdict;
end
endmodule // tb_dmc_mode_ctrl
